/* File: bench/tb.sv */
// Self-checking bench for the internal error injection register bank.
// Assumes iei_pkg is compiled first; bench acts as the AXI4-Lite master.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import iei_pkg::*;
  // ------
  // Signals
  // ------
  logic aclk, aresetn;
  iei_addr_t s_aw, s_ar;
  iei_wdata_t s_w;
  iei_rdata_t s_r;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, irq;
  logic [1:0] s_bresp, rsp;
  logic [IEI_NERR-1:0] hw_error;
  iei_report_t report_q;
  logic [31:0] rd;
  int n_mismatch, cmp_count;

  // Device under test
  iei_inject_regs u_iei_inject_regs (
    .aclk(aclk), .aresetn(aresetn),
    .s_aw(s_aw), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_w(s_w), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_ar(s_ar), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_r(s_r), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .hw_error(hw_error), .report_q(report_q), .irq(irq)
  );

  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ------
  // Shared tasks
  // ------
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stuck(input int n);
    if (n > 50) begin
      check("handshake", 32'h0, 32'h1);
      end_of_test();
    end
  endtask

  // Write cycle; address and data released each at its own acceptance
  task automatic wr(input logic [IEI_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_p, w_p;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_aw <= '{addr: a, prot: 3'h0};
    s_w <= '{data: d, strb: 4'hf};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_awready) begin
        aw_p = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w_p && s_wready) begin
        w_p = 1'b0;
        s_wvalid <= 1'b0;
      end
      n++;
      stuck(n);
    end
    while (!s_bvalid) begin
      @(posedge aclk);
      n++;
      stuck(n);
    end
    r = s_bresp;
  endtask

  // Read cycle
  task automatic rd_reg(input logic [IEI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_ar <= '{addr: a, prot: 3'h0};
    s_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      stuck(n);
    end while (!s_arready);
    s_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
      stuck(n);
    end while (!s_rvalid);
    d = s_r.data;
    r = s_r.resp;
  endtask

  task automatic wchk(input logic [IEI_AW-1:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    check("write resp", {30'h0, rsp}, {30'h0, IEI_RESP_OKAY});
  endtask

  task automatic rchk(input string what, input logic [IEI_AW-1:0] a, input logic [31:0] e);
    rd_reg(a, rd, rsp);
    check("read resp", {30'h0, rsp}, {30'h0, IEI_RESP_OKAY});
    check(what, rd, e);
  endtask

  // Let two edges pass so the report and irq outputs settle
  task automatic settle();
    repeat (2) @(posedge aclk);
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    rchk("inject", IEI_OFF_INJECT, 32'h0);
    rchk("status", IEI_OFF_STATUS, IEI_STATUS_RST);
    rchk("mask", IEI_OFF_MASK, IEI_MASK_RST);
    rchk("severity", IEI_OFF_SEVERITY, IEI_SEVERITY_RST);
    check("report", {30'h0, report_q}, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    rd_reg(12'hffc, rd, rsp);
    check("unmapped read", {30'h0, rsp}, {30'h0, IEI_RESP_SLVERR});
    wr(12'hffc, 32'hffff_ffff, rsp);
    check("unmapped write", {30'h0, rsp}, {30'h0, IEI_RESP_SLVERR});
  endtask

  // Every bit position in turn, reserved ones included
  task automatic t_each_bit();
    logic [31:0] b;
    for (int i = 0; i < 32; i++) begin
      b = 32'h1 << i;
      wchk(IEI_OFF_INJECT, b);
      rchk("status bit", IEI_OFF_STATUS, b & 32'h0007_fff7);
      rchk("inject rd", IEI_OFF_INJECT, 32'h0);
      wchk(IEI_OFF_STATUS, 32'hffff_ffff);
      rchk("status clr", IEI_OFF_STATUS, 32'h0);
    end
  endtask

  task automatic t_zero_all();
    wchk(IEI_OFF_INJECT, 32'h0);
    rchk("zero write", IEI_OFF_STATUS, 32'h0);
    wchk(IEI_OFF_INJECT, 32'hffff_ffff);
    rchk("all ones", IEI_OFF_STATUS, 32'h0007_fff7);
    rchk("inject rd", IEI_OFF_INJECT, 32'h0);
    wchk(IEI_OFF_STATUS, 32'hffff_ffff);
  endtask

  // Severity steers the report, mask silences it
  task automatic t_report();
    wchk(IEI_OFF_MASK, 32'hffff_fffe);
    wchk(IEI_OFF_INJECT, 32'h0000_0001);
    settle();
    check("corr only", {30'h0, report_q}, 32'h2);
    wchk(IEI_OFF_SEVERITY, IEI_SEVERITY_RST | 32'h1);
    settle();
    check("uncorr only", {30'h0, report_q}, 32'h1);
    wchk(IEI_OFF_MASK, 32'hffff_ffff);
    settle();
    check("masked", {30'h0, report_q}, 32'h0);
    wchk(IEI_OFF_SEVERITY, IEI_SEVERITY_RST);
    wchk(IEI_OFF_MASK, 32'h0);
    wchk(IEI_OFF_STATUS, 32'hffff_ffff);
  endtask

  // Inject event interrupt: raise, clear, mask
  task automatic t_irq();
    wchk(IEI_OFF_IRQ_STATUS, 32'h7);
    wchk(IEI_OFF_IRQ_MASK, 32'h1);
    wchk(IEI_OFF_INJECT, 32'h0000_0004);
    settle();
    check("irq raised", {31'h0, irq}, 32'h1);
    wchk(IEI_OFF_IRQ_STATUS, 32'h1);
    settle();
    check("irq cleared", {31'h0, irq}, 32'h0);
    wchk(IEI_OFF_IRQ_MASK, 32'h0);
    wchk(IEI_OFF_INJECT, 32'h0000_0004);
    settle();
    check("irq masked", {31'h0, irq}, 32'h0);
    // Inject event plus correctable level, enable only the correctable source
    rchk("irq status", IEI_OFF_IRQ_STATUS, 32'h0000_0003);
    wchk(IEI_OFF_IRQ_MASK, 32'h2);
    check("irq corr", {31'h0, irq}, 32'h1);
    wchk(IEI_OFF_STATUS, 32'hffff_ffff);
    wchk(IEI_OFF_IRQ_STATUS, 32'h7);
  endtask

  // Real events land in the same status bits as injections
  task automatic t_hw();
    hw_error <= 19'h0_0020;
    @(posedge aclk);
    hw_error <= 19'h0_0008;
    @(posedge aclk);
    hw_error <= 19'h0;
    rchk("hw event", IEI_OFF_STATUS, 32'h0000_0020);
    wchk(IEI_OFF_STATUS, 32'hffff_ffff);
    // Event standing over a clear write keeps the bit set
    hw_error <= 19'h0_0040;
    wchk(IEI_OFF_STATUS, 32'hffff_ffff);
    hw_error <= 19'h0;
    rchk("set beats clear", IEI_OFF_STATUS, 32'h0000_0040);
    wchk(IEI_OFF_STATUS, 32'hffff_ffff);
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    aresetn <= 1'b0;
    s_aw <= '0;
    s_w <= '0;
    s_ar <= '0;
    s_awvalid <= 1'b0;
    s_wvalid <= 1'b0;
    s_arvalid <= 1'b0;
    s_bready <= 1'b1;
    s_rready <= 1'b1;
    hw_error <= '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_each_bit();
    t_zero_all();
    t_report();
    t_irq();
    t_hw();
    end_of_test();
  end
endmodule // tb
`default_nettype wire

/* File: pkg/iei_pkg.sv */
// Package for the internal error injection register bank.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package iei_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned IEI_AW = 12;
  localparam int unsigned IEI_DW = 32;
  localparam int unsigned IEI_NERR = 19;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [IEI_AW-1:0] IEI_OFF_INJECT = 12'h490;
  localparam logic [IEI_AW-1:0] IEI_OFF_STATUS = 12'h480;
  localparam logic [IEI_AW-1:0] IEI_OFF_MASK = 12'h484;
  localparam logic [IEI_AW-1:0] IEI_OFF_SEVERITY = 12'h488;
  localparam logic [IEI_AW-1:0] IEI_OFF_IRQ_STATUS = 12'h494;
  localparam logic [IEI_AW-1:0] IEI_OFF_IRQ_MASK = 12'h498;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  // Implemented error bits: 0-2 and 4-18; bit 3 and 31:19 reserved
  localparam logic [IEI_DW-1:0] IEI_IMPL_MASK = 32'h0007_fff7;
  localparam logic [IEI_DW-1:0] IEI_INJECT_RST = 32'h0000_0000;
  localparam logic [IEI_DW-1:0] IEI_STATUS_RST = 32'h0000_0000;
  localparam logic [IEI_DW-1:0] IEI_MASK_RST = 32'h0000_0000;
  localparam logic [IEI_DW-1:0] IEI_SEVERITY_RST = 32'h0004_d500;
  localparam logic [IEI_DW-1:0] IEI_ZERO = 32'h0000_0000;
  // Interrupt status / mask bits
  localparam int unsigned IEI_NIRQ = 3;
  localparam int unsigned IEI_IRQ_INJECT = 0;
  localparam int unsigned IEI_IRQ_CORR = 1;
  localparam int unsigned IEI_IRQ_UNCORR = 2;
  localparam logic [IEI_NIRQ-1:0] IEI_IRQ_RST = 3'h0;

  // Error bit positions
  localparam int unsigned IEI_B_ING_POSTED_TO = 0;
  localparam int unsigned IEI_B_REPLAY_CTRL_DBE = 18;

  // AXI responses
  localparam logic [1:0] IEI_RESP_OKAY = 2'h0;
  localparam logic [1:0] IEI_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [IEI_AW-1:0] addr;
    logic [2:0] prot;
  } iei_addr_t;

  typedef struct packed {
    logic [IEI_DW-1:0] data;
    logic [3:0] strb;
  } iei_wdata_t;

  typedef struct packed {
    logic [IEI_DW-1:0] data;
    logic [1:0] resp;
  } iei_rdata_t;

  // Error reporting outputs
  typedef struct packed {
    logic corr;
    logic uncorr;
  } iei_report_t;

endpackage

/* File: rtl/iei_inject_regs.sv */
// Internal error injection register bank with status, mask, severity.
// Assumes an AXI4-Lite master, one clock aclk, synchronous reset aresetn.
// Operation
// - A one written to an implemented test bit sets the same status bit as a real error would.
// - Implemented test bits always read back as zero.
// - The test register is a 32-bit register at offset 0x490.
// - Bits 0 to 2 inject ingress posted, non-posted and completion time-outs; bit 3 is reserved.
// - Bits 4 to 6 inject egress posted, non-posted and completion time-outs.
// - Bits 7 to 10 inject ingress data single, data double, control single and double errors.
// - Bits 11 to 14 inject egress data single, data double, control single and double errors.
// - Bit 15 injects end-to-end parity error and bit 16 the unreliable link condition.
// - Bits 17 and 18 inject replay control single and double errors; 31:19 are reserved.
// - Unmasked status reports uncorrectable when severity is set, else correctable.
`timescale 1ns/1ns
`default_nettype none
module iei_inject_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire iei_pkg::iei_addr_t s_aw,
  input wire logic s_awvalid,
  output logic s_awready,
  // AXI4-Lite write data
  input wire iei_pkg::iei_wdata_t s_w,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read address
  input wire iei_pkg::iei_addr_t s_ar,
  input wire logic s_arvalid,
  output logic s_arready,
  // AXI4-Lite read data
  output iei_pkg::iei_rdata_t s_r,
  output logic s_rvalid,
  input wire logic s_rready,
  // Real internal error events from the switch core
  input wire logic [iei_pkg::IEI_NERR-1:0] hw_error,
  // Error reporting
  output iei_pkg::iei_report_t report_q,
  // Interrupt
  output logic irq
);
  import iei_pkg::*;

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [IEI_AW-1:0] awaddr_q;
  logic [IEI_DW-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [IEI_DW-1:0] wmask;

  assign s_awready = !aw_held_q && !s_bvalid;
  assign s_wready = !w_held_q && !s_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_bvalid;

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= IEI_ZERO;
      wstrb_q <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_aw.addr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_w.data;
        wstrb_q <= s_w.strb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Byte enables widened to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wstrb_q[i]}};
    end
  end

  // Word address decode
  logic wr_inject, wr_status, wr_mask, wr_sev, wr_irqs, wr_irqm, wr_hit;
  assign wr_inject = wr_fire && (awaddr_q[IEI_AW-1:2] == IEI_OFF_INJECT[IEI_AW-1:2]);
  assign wr_status = wr_fire && (awaddr_q[IEI_AW-1:2] == IEI_OFF_STATUS[IEI_AW-1:2]);
  assign wr_mask = wr_fire && (awaddr_q[IEI_AW-1:2] == IEI_OFF_MASK[IEI_AW-1:2]);
  assign wr_sev = wr_fire && (awaddr_q[IEI_AW-1:2] == IEI_OFF_SEVERITY[IEI_AW-1:2]);
  assign wr_irqs = wr_fire && (awaddr_q[IEI_AW-1:2] == IEI_OFF_IRQ_STATUS[IEI_AW-1:2]);
  assign wr_irqm = wr_fire && (awaddr_q[IEI_AW-1:2] == IEI_OFF_IRQ_MASK[IEI_AW-1:2]);
  assign wr_hit = wr_inject || wr_status || wr_mask || wr_sev || wr_irqs || wr_irqm;

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= IEI_RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_hit ? IEI_RESP_OKAY : IEI_RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Injection pulse and status bits
  // ----------------------------------------------------------------
  logic [IEI_DW-1:0] inject_pulse; // Combinational, lives one cycle only
  logic [IEI_DW-1:0] clear_pulse;
  logic [IEI_DW-1:0] status;
  logic [IEI_DW-1:0] mask_q;
  logic [IEI_DW-1:0] sev_q;

  // Ones only, reserved positions dropped
  assign inject_pulse = wr_inject ? (wdata_q & wmask & IEI_IMPL_MASK) : IEI_ZERO;
  assign clear_pulse = wr_status ? (wdata_q & wmask & IEI_IMPL_MASK) : IEI_ZERO;

  // One sticky bit per error type, reserved bits tied low
  genvar g;
  generate
    for (g = 0; g < IEI_DW; g++) begin : g_status
      if (IEI_IMPL_MASK[g]) begin : g_impl
        // Bits 0-2, 4-6, 7-10, 11-14, 15-16, 17-18 each map one-to-one
        iei_status_bit u_bit (
          .aclk(aclk),
          .aresetn(aresetn),
          .hw_event(hw_error[g]),
          .inject_pulse(inject_pulse[g]),
          .clear_pulse(clear_pulse[g]),
          .status_q(status[g])
        );
      end else begin : g_rsvd
        assign status[g] = 1'b0;
      end
    end
  endgenerate

  // Mask and severity registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= IEI_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= ((mask_q & ~wmask) | (wdata_q & wmask)) & IEI_IMPL_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sev_q <= IEI_SEVERITY_RST;
    end else if (wr_sev) begin
      sev_q <= ((sev_q & ~wmask) | (wdata_q & wmask)) & IEI_IMPL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Error reporting
  // ----------------------------------------------------------------
  logic [IEI_DW-1:0] active;
  assign active = status & ~mask_q;

  // Severity splits each unmasked error between the two paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      report_q <= '0;
    end else begin
      report_q.uncorr <= |(active & sev_q);
      report_q.corr <= |(active & ~sev_q);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IEI_NIRQ-1:0] irq_sts_q;
  logic [IEI_NIRQ-1:0] irq_msk_q;
  logic [IEI_NIRQ-1:0] irq_evt;

  assign irq_evt[IEI_IRQ_INJECT] = |inject_pulse;
  assign irq_evt[IEI_IRQ_CORR] = |(active & ~sev_q);
  assign irq_evt[IEI_IRQ_UNCORR] = |(active & sev_q);

  // Sticky status, write one to clear, event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_q <= IEI_IRQ_RST;
    end else begin
      for (int i = 0; i < IEI_NIRQ; i++) begin
        if (irq_evt[i]) begin
          irq_sts_q[i] <= 1'b1;
        end else if (wr_irqs && wstrb_q[0] && wdata_q[i]) begin
          irq_sts_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_msk_q <= IEI_IRQ_RST;
    end else if (wr_irqm && wstrb_q[0]) begin
      irq_msk_q <= wdata_q[IEI_NIRQ-1:0];
    end
  end

  assign irq = |(irq_sts_q & irq_msk_q);

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [IEI_DW-1:0] rd_mux;
  logic rd_hit;
  logic [IEI_AW-1:0] raddr;

  assign s_arready = !s_rvalid;
  assign raddr = s_ar.addr;

  // Read data select; test register always reads zero
  always_comb begin
    rd_mux = IEI_ZERO;
    rd_hit = 1'b1;
    unique case (raddr[IEI_AW-1:2])
      IEI_OFF_INJECT[IEI_AW-1:2]: rd_mux = IEI_ZERO;
      IEI_OFF_STATUS[IEI_AW-1:2]: rd_mux = status;
      IEI_OFF_MASK[IEI_AW-1:2]: rd_mux = mask_q;
      IEI_OFF_SEVERITY[IEI_AW-1:2]: rd_mux = sev_q;
      IEI_OFF_IRQ_STATUS[IEI_AW-1:2]: rd_mux = {{(IEI_DW-IEI_NIRQ){1'b0}}, irq_sts_q};
      IEI_OFF_IRQ_MASK[IEI_AW-1:2]: rd_mux = {{(IEI_DW-IEI_NIRQ){1'b0}}, irq_msk_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_r <= '0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_r.data <= rd_mux;
      s_r.resp <= rd_hit ? IEI_RESP_OKAY : IEI_RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_inject_sets_status: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_inject && (wdata_q[IEI_B_ING_POSTED_TO] && wstrb_q[0])
    |=> status[IEI_B_ING_POSTED_TO])
    else $error("injected bit 0 did not set status");

  a_inject_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_arvalid && s_arready && (raddr[IEI_AW-1:2] == IEI_OFF_INJECT[IEI_AW-1:2])
    |=> s_rvalid && (s_r.data == IEI_ZERO) && (s_r.resp == IEI_RESP_OKAY))
    else $error("test register read not zero");

  a_inject_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && (awaddr_q[IEI_AW-1:2] == IEI_OFF_INJECT[IEI_AW-1:2])
    |=> s_bvalid && (s_bresp == IEI_RESP_OKAY))
    else $error("test register write refused");

  a_reserved_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (inject_pulse & ~IEI_IMPL_MASK) == IEI_ZERO)
    else $error("reserved test bit injected");

  a_top_bit_inject: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_inject && wdata_q[IEI_B_REPLAY_CTRL_DBE] && wstrb_q[2]
    |=> status[IEI_B_REPLAY_CTRL_DBE])
    else $error("bit 18 injection lost");

  a_zero_no_effect: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_inject && (wdata_q == IEI_ZERO) && !(|hw_error) && !wr_status
    |=> status == $past(status))
    else $error("zero write changed status");

  a_uncorr_report: assert property (@(posedge aclk) disable iff (!aresetn)
    |(active & sev_q) |=> report_q.uncorr)
    else $error("uncorrectable not reported");

  a_corr_report: assert property (@(posedge aclk) disable iff (!aresetn)
    !(|(active & ~sev_q)) |=> !report_q.corr)
    else $error("correctable reported without cause");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");

  c_inject_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_inject);
  c_uncorr_path: cover property (@(posedge aclk) disable iff (!aresetn) report_q.uncorr);
  c_corr_path: cover property (@(posedge aclk) disable iff (!aresetn) report_q.corr);
  c_irq_raise: cover property (@(posedge aclk) disable iff (!aresetn) irq);

endmodule // iei_inject_regs
`default_nettype wire

/* File: rtl/iei_status_bit.sv */
// One sticky internal error status bit with inject and clear.
// Assumes all inputs are synchronous to aclk.
`timescale 1ns/1ns
`default_nettype none
module iei_status_bit (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Set sources
  input wire logic hw_event,
  input wire logic inject_pulse,
  // Write-one-to-clear
  input wire logic clear_pulse,
  // State
  output logic status_q
);
  import iei_pkg::*;

  // Set wins over clear, as a real error must never be lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 1'b0;
    end else if (hw_event || inject_pulse) begin
      status_q <= 1'b1;
    end else if (clear_pulse) begin
      status_q <= 1'b0;
    end
  end

  a_set_beats_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (hw_event || inject_pulse) |=> status_q)
    else $error("status bit not set after event");

endmodule // iei_status_bit
`default_nettype wire
